// [src/wotp_pkg.sv]
// Constants, command codes and helpers for the wiper and one-time-programmable store block.
// Assumes a 250 MHz core clock; every consumer imports the whole package.
package wotp_pkg;

   // Frame layout
   localparam int          FRAME_W      = 16;
   localparam int          WIPER_W      = 10;
   localparam int          CMD_MSB      = 13;
   localparam int          CMD_LSB      = 10;
   localparam int          ADDR_MSB     = 4;
   localparam int          BITCNT_W     = 4;

   // Command codes
   localparam logic [3:0]  CMD_NOP      = 4'h0;
   localparam logic [3:0]  CMD_WR_WIPER = 4'h1;
   localparam logic [3:0]  CMD_RD_WIPER = 4'h2;
   localparam logic [3:0]  CMD_STORE    = 4'h3;
   localparam logic [3:0]  CMD_REFRESH  = 4'h4;
   localparam logic [3:0]  CMD_RD_MEM   = 4'h5;
   localparam logic [3:0]  CMD_WR_CTRL  = 4'h6;
   localparam logic [3:0]  CMD_RD_CTRL  = 4'h7;
   localparam logic [3:0]  CMD_SHUTDOWN = 4'h8;

   // Control field positions within the data bits
   localparam int          CTRL_PROG_EN = 0;
   localparam int          CTRL_WR_EN   = 1;
   localparam int          CTRL_CAL     = 2;
   localparam int          CTRL_OK      = 3;

   // Reset values
   localparam logic        CTRL_RESET   = 1'b0;
   localparam logic [9:0]  MIDSCALE     = 10'h200;

   // Stored slots and status addresses
   localparam int          SLOT_COUNT   = 20;
   localparam int          SLOT_AW      = 5;
   localparam logic [4:0]  ADDR_LAST    = 5'h13;
   localparam logic [4:0]  ADDR_THERMO_LO = 5'h14;
   localparam logic [4:0]  ADDR_THERMO_HI = 5'h15;
   localparam int          THERMO_W     = 10;

   // Store timing
   localparam int          CLK_MHZ      = 250;
   localparam int          STORE_TIME_US = 8000;
   localparam int          STORE_CYCLES = STORE_TIME_US * CLK_MHZ;

   // Pads a data field into a full output word
   function automatic logic [FRAME_W-1:0] pad_word(input logic [WIPER_W-1:0] d);
      pad_word = {{(FRAME_W-WIPER_W){1'b0}}, d};
   endfunction

   // Thermometer code of how many slots above base are used, capped at THERMO_W
   function automatic logic [THERMO_W-1:0] thermo(input logic [SLOT_AW-1:0] used,
                                                  input logic [SLOT_AW-1:0] base);
      logic [THERMO_W-1:0] t;
      t = '0;
      for (int i = 0; i < THERMO_W; i++) begin
         if (used > (base + SLOT_AW'(i))) begin
            t[i] = 1'b1;
         end
      end
      thermo = t;
   endfunction

endpackage

// [src/wotp_sync.sv]
// Two-flop synchronisers for a group of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/1ps
`default_nettype none
module wotp_sync
   import wotp_pkg::*;
#(
   parameter int             W       = 4,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         rst_b_i,
   // Pins in, synchronised levels out
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } wotp_sync_t;

   wotp_sync_t s;
   wotp_sync_t next_s;

   always_comb begin
      next_s        = s;
      next_s.meta   = async_i;
      next_s.stable = s.meta;
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= '{meta: RST_VAL, stable: RST_VAL};
      end else begin
         s <= next_s;
      end
   end

   assign sync_o = s.stable;

endmodule
`default_nettype wire

// [src/wotp_mem.sv]
// Storage array for the programmed wiper slots, one write port and one registered read port.
// Contents are undefined until written; the owner only reads slots it has written.
`timescale 1ns/1ps
`default_nettype none
module wotp_mem
   import wotp_pkg::*;
#(
   parameter int DW    = WIPER_W,
   parameter int DEPTH = SLOT_COUNT,
   parameter int AW    = SLOT_AW
) (
   // Clock
   input  wire logic          ref_clk_i,
   // Write port
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [DW-1:0] wdata_i,
   // Read port
   input  wire logic [AW-1:0] raddr_i,
   output logic      [DW-1:0] rdata_o
);

   logic [DW-1:0] cells [DEPTH];

   // Read data lands one edge after the address is presented
   always_ff @(posedge ref_clk_i) begin
      if (we_i) begin
         cells[waddr_i] <= wdata_i;
      end
      rdata_o <= cells[raddr_i];
   end

endmodule
`default_nettype wire

// [src/wotp_ctrl.sv]
// Control register, wiper register, serial frame decode and slot store sequencer.
// Assumes serial pins are asynchronous to ref_clk_i and the serial clock is well below it.
`timescale 1ns/1ps
`default_nettype none
module wotp_ctrl
   import wotp_pkg::*;
#(
   parameter int STORE_CYC = STORE_CYCLES
) (
   // Clock and reset
   input  wire logic               ref_clk_i,
   input  wire logic               rst_b_i,
   // Serial link pins
   input  wire logic               sclk_i,
   input  wire logic               sdin_i,
   input  wire logic               frame_select_n_i,
   output logic                    sdo_o,
   // Hardware reset pin, rising edge refreshes the wiper only while idle and no store is starting; dropped during a store or reload
   input  wire logic               hw_reset_n_i,
   // Device outputs
   output logic                    program_done_o,
   output logic [WIPER_W-1:0]      wiper_o,
   output logic                    calibration_select_o
);

   localparam int                  TIMER_W  = $clog2(STORE_CYC + 1);
   localparam logic [TIMER_W-1:0]  TIMER_END = TIMER_W'(STORE_CYC - 1);

   // Positions of the pins inside the synchroniser group
   localparam int                  PIN_CNT  = 4;
   localparam int                  PIN_CS   = 0;
   localparam int                  PIN_SCLK = 1;
   localparam int                  PIN_SDIN = 2;
   localparam int                  PIN_HWR  = 3;
   // Idle levels: reset pin high, data and clock low, select high
   localparam logic [PIN_CNT-1:0]  PIN_IDLE = 4'h9;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RST_ADDR,
      ST_RST_WAIT,
      ST_RST_LOAD,
      ST_PROG,
      ST_VER_WAIT,
      ST_VER_CHK
   } wotp_state_t;

   typedef struct packed {
      wotp_state_t          state;
      logic                 sclk_q;
      logic                 cs_q;
      logic                 hwr_q;
      logic [FRAME_W-1:0]   rx;
      logic [FRAME_W-1:0]   tx;
      logic [BITCNT_W-1:0]  bit_cnt;
      logic                 bits_seen;
      logic                 sdo;
      logic [WIPER_W-1:0]   wiper;
      logic                 prog_en;
      logic                 wr_en;
      logic                 cal;
      logic                 ok;
      logic [SLOT_AW-1:0]   used;
      logic [FRAME_W-1:0]   resp;
      logic                 resp_mem;
      logic [SLOT_AW-1:0]   raddr;
      logic                 we;
      logic [SLOT_AW-1:0]   waddr;
      logic [WIPER_W-1:0]   wdata;
      logic [TIMER_W-1:0]   timer;
      logic                 done;
   } wotp_ctrl_t;

   localparam wotp_ctrl_t RESET_S = '{
      state:     ST_RST_ADDR,
      sclk_q:    1'b0,
      cs_q:      1'b1,
      hwr_q:     1'b1,
      rx:        '0,
      tx:        '0,
      bit_cnt:   '0,
      bits_seen: 1'b0,
      sdo:       1'b0,
      wiper:     MIDSCALE,
      prog_en:   CTRL_RESET,
      wr_en:     CTRL_RESET,
      cal:       CTRL_RESET,
      ok:        CTRL_RESET,
      used:      '0,
      resp:      '0,
      resp_mem:  1'b0,
      raddr:     '0,
      we:        1'b0,
      waddr:     '0,
      wdata:     '0,
      timer:     '0,
      done:      1'b1
   };

   wotp_ctrl_t          s;
   wotp_ctrl_t          next_s;
   logic [PIN_CNT-1:0]  pins_sync;
   logic [WIPER_W-1:0]  mem_rdata;

   // Serial clock, data, select and reset pin; idle levels keep edges quiet at release
   wotp_sync #(
      .W       (PIN_CNT),
      .RST_VAL (PIN_IDLE)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .async_i   ({hw_reset_n_i, sdin_i, sclk_i, frame_select_n_i}),
      .sync_o    (pins_sync)
   );

   wotp_mem #(
      .DW    (WIPER_W),
      .DEPTH (SLOT_COUNT),
      .AW    (SLOT_AW)
   ) u_mem (
      .ref_clk_i (ref_clk_i),
      .we_i      (s.we),
      .waddr_i   (s.waddr),
      .wdata_i   (s.wdata),
      .raddr_i   (s.raddr),
      .rdata_o   (mem_rdata)
   );

   always_comb begin
      logic                cs_s;
      logic                sclk_s;
      logic                sdin_s;
      logic                hwr_s;
      logic                cs_fall;
      logic                cs_rise;
      logic                sclk_fall;
      logic                hw_rise;
      logic                frame_ok;
      logic                refresh;
      logic [3:0]          cmd;
      logic [WIPER_W-1:0]  data;
      logic [SLOT_AW-1:0]  addr;
      logic [FRAME_W-1:0]  load_word;

      cs_s      = pins_sync[PIN_CS];
      sclk_s    = pins_sync[PIN_SCLK];
      sdin_s    = pins_sync[PIN_SDIN];
      hwr_s     = pins_sync[PIN_HWR];
      cs_fall   = !cs_s && s.cs_q;
      cs_rise   = cs_s && !s.cs_q;
      sclk_fall = !sclk_s && s.sclk_q;
      hw_rise   = hwr_s && !s.hwr_q;
      cmd       = s.rx[CMD_MSB:CMD_LSB];
      data      = s.rx[WIPER_W-1:0];
      addr      = s.rx[ADDR_MSB:0];
      load_word = s.resp_mem ? pad_word(mem_rdata) : s.resp;
      refresh   = 1'b0;
      // Frames arriving while a store or refresh runs are dropped whole
      frame_ok  = cs_rise && s.bits_seen && (s.bit_cnt == '0) && (s.state == ST_IDLE);

      next_s        = s;
      next_s.we     = 1'b0;
      next_s.sclk_q = sclk_s;
      next_s.cs_q   = cs_s;
      next_s.hwr_q  = hwr_s;

      // Shift path: first output bit is ready at select, later ones change on falling edges
      if (cs_fall) begin
         next_s.tx        = load_word;
         next_s.sdo       = load_word[FRAME_W-1];
         next_s.bit_cnt   = '0;
         next_s.bits_seen = 1'b0;
      end else if (!cs_s && sclk_fall) begin
         next_s.rx        = {s.rx[FRAME_W-2:0], sdin_s};
         next_s.tx        = {s.tx[FRAME_W-2:0], sdin_s};
         next_s.sdo       = s.tx[FRAME_W-2];
         next_s.bit_cnt   = s.bit_cnt + BITCNT_W'(1);
         next_s.bits_seen = 1'b1;
      end

      if (frame_ok) begin
         // Default answer echoes the frame just decoded
         next_s.resp     = s.rx;
         next_s.resp_mem = 1'b0;
         unique case (cmd)
            CMD_WR_WIPER: begin
               if (s.wr_en) begin
                  next_s.wiper = data;
               end
            end
            CMD_RD_WIPER: begin
               next_s.resp = pad_word(s.wiper);
            end
            CMD_STORE: begin
               if (s.prog_en) begin
                  if (s.used < SLOT_AW'(SLOT_COUNT)) begin
                     next_s.we    = 1'b1;
                     next_s.waddr = s.used;
                     next_s.wdata = s.wiper;
                     next_s.ok    = 1'b0;
                     next_s.timer = '0;
                     next_s.state = ST_PROG;
                  end else begin
                     next_s.ok = 1'b0;
                  end
               end
            end
            CMD_REFRESH: begin
               refresh = 1'b1;
            end
            CMD_RD_MEM: begin
               if (addr <= ADDR_LAST) begin
                  if (addr < s.used) begin
                     next_s.raddr    = addr;
                     next_s.resp_mem = 1'b1;
                  end else begin
                     next_s.resp = '0;
                  end
               end else if (addr == ADDR_THERMO_LO) begin
                  next_s.resp = pad_word(thermo(s.used, '0));
               end else if (addr == ADDR_THERMO_HI) begin
                  next_s.resp = pad_word(thermo(s.used, SLOT_AW'(THERMO_W)));
               end else begin
                  next_s.resp = '0;
               end
            end
            CMD_WR_CTRL: begin
               next_s.prog_en = data[CTRL_PROG_EN];
               next_s.wr_en   = data[CTRL_WR_EN];
               next_s.cal     = data[CTRL_CAL];
               // Dropping write enable freezes the wiper back onto the stored value
               if (s.wr_en && !data[CTRL_WR_EN]) begin
                  next_s.state = ST_RST_ADDR;
               end
            end
            CMD_RD_CTRL: begin
               next_s.resp = pad_word({{(WIPER_W-4){1'b0}}, s.ok, s.cal, s.wr_en, s.prog_en});
            end
            default: begin
               // No-op, shutdown and unused codes change no state here
            end
         endcase
      end

      // Reset pin edge or refresh command: reload wiper and restore control defaults.
      // A pin edge meeting a store decode is dropped so the started write is still checked.
      if ((hw_rise && (s.state == ST_IDLE) && (next_s.state != ST_PROG)) || refresh) begin
         next_s.prog_en  = CTRL_RESET;
         next_s.wr_en    = CTRL_RESET;
         next_s.cal      = CTRL_RESET;
         next_s.ok       = CTRL_RESET;
         next_s.resp_mem = 1'b0;
         next_s.state    = ST_RST_ADDR;
      end

      unique case (s.state)
         ST_IDLE: begin
         end
         ST_RST_ADDR: begin
            if (s.used == '0) begin
               next_s.wiper = MIDSCALE;
               next_s.state = ST_IDLE;
            end else begin
               next_s.raddr = s.used - SLOT_AW'(1);
               next_s.state = ST_RST_WAIT;
            end
         end
         ST_RST_WAIT: begin
            next_s.state = ST_RST_LOAD;
         end
         ST_RST_LOAD: begin
            next_s.wiper = mem_rdata;
            next_s.state = ST_IDLE;
         end
         ST_PROG: begin
            // The array write lands on the first counted cycle; the count sets the store length
            next_s.timer = s.timer + TIMER_W'(1);
            if (s.timer == TIMER_END) begin
               next_s.raddr = s.waddr;
               next_s.state = ST_VER_WAIT;
            end
         end
         ST_VER_WAIT: begin
            next_s.state = ST_VER_CHK;
         end
         ST_VER_CHK: begin
            // A slot is spent whether or not the check passes
            next_s.ok    = (mem_rdata == s.wdata);
            next_s.used  = s.used + SLOT_AW'(1);
            next_s.state = ST_IDLE;
         end
         default: begin
            // Unused state code: recover through a refresh so the wiper is reloaded
            next_s.state = ST_RST_ADDR;
         end
      endcase

      // Taken from the next state so done falls on the edge that raises the write pulse
      next_s.done = !((next_s.state == ST_PROG) || (next_s.state == ST_VER_WAIT) ||
                      (next_s.state == ST_VER_CHK));
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= RESET_S;
      end else begin
         s <= next_s;
      end
   end

   assign sdo_o                = s.sdo;
   assign program_done_o       = s.done;
   assign wiper_o              = s.wiper;
   assign calibration_select_o = s.cal;

endmodule
`default_nettype wire

// [verif/wotp_ctrl_props.sv]
// Port-level checks of the wiper and store controller.
// Assumes a single core clock domain with active-low async reset.
`timescale 1ns/1ps
`default_nettype none
module wotp_ctrl_props
   import wotp_pkg::*;
#(
   parameter int STORE_CYC = STORE_CYCLES
) (
   // Clock and reset
   input wire logic               ref_clk_i,
   input wire logic               rst_b_i,
   // Watched ports
   input wire logic               sclk_i,
   input wire logic               sdin_i,
   input wire logic               frame_select_n_i,
   input wire logic               sdo_o,
   input wire logic               hw_reset_n_i,
   input wire logic               program_done_o,
   input wire logic [WIPER_W-1:0] wiper_o,
   input wire logic               calibration_select_o
);
   int low_cnt;

   // Counts how long the done output has been low
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         low_cnt <= 0;
      end else begin
         low_cnt <= program_done_o ? 0 : low_cnt + 1;
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_idle5;
      frame_select_n_i [*5];
   endsequence
   sequence s_shift8;
      (!frame_select_n_i && hw_reset_n_i) [*8];
   endsequence
   sequence s_sclk_high5;
      (sclk_i && !frame_select_n_i) [*5];
   endsequence

   a_reset_vals: assert property ($rose(rst_b_i) |->
      wiper_o == MIDSCALE && program_done_o && !calibration_select_o)
      else $error("reset values wrong");
   a_store_long: assert property ($rose(program_done_o) |-> low_cnt >= STORE_CYC)
      else $error("store ended too early");
   a_store_bound: assert property (low_cnt <= STORE_CYC + 6)
      else $error("store never ended");
   a_done_cause: assert property ($fell(program_done_o) |->
      frame_select_n_i && $past(frame_select_n_i, 3))
      else $error("done fell outside a frame end");
   a_wiper_store: assert property (!program_done_o |=> $stable(wiper_o))
      else $error("wiper moved during store");
   a_cal_store: assert property (!program_done_o |=> $stable(calibration_select_o))
      else $error("control moved during store");
   a_wiper_mid: assert property (s_shift8 |-> $stable(wiper_o))
      else $error("wiper moved inside a frame");
   a_cal_mid: assert property (s_shift8 |-> $stable(calibration_select_o))
      else $error("control moved inside a frame");
   a_sdo_idle: assert property (s_idle5 |-> $stable(sdo_o))
      else $error("serial out moved while idle");
   a_sdo_sclk: assert property (s_sclk_high5 |-> $stable(sdo_o))
      else $error("serial out moved with clock high");
endmodule
`default_nettype wire

// [verif/wotp_host.sv]
// Serial host model: frames MSB first, 12 core cycles per bit.
// Assumes the caller keeps frames apart; clock idles low.
`timescale 1ns/1ps
`default_nettype none
module wotp_host (
   // Clock
   input  wire logic  ref_clk_i,
   // Serial pins
   input  wire logic  sdo_i,
   output logic       sclk_o,
   output logic       sdin_o,
   output logic       frame_select_n_o,
   // Reply of the last frame
   output logic [15:0] rsp_o,
   output logic       rsp_v_o
);
   initial begin
      sclk_o = 1'b0;
      sdin_o = 1'b0;
      frame_select_n_o = 1'b1;
      rsp_o = 16'h0000;
      rsp_v_o = 1'b0;
   end

   // Data changes on the rising edge so it is settled at the falling one
   task automatic xfer(input logic [31:0] w, input int n);
      @(posedge ref_clk_i) frame_select_n_o <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      for (int i = n - 1; i >= 0; i--) begin
         sclk_o <= 1'b1;
         rsp_o <= {rsp_o[14:0], sdo_i};
         sdin_o <= w[i];
         repeat (6) @(posedge ref_clk_i);
         sclk_o <= 1'b0;
         repeat (6) @(posedge ref_clk_i);
      end
      frame_select_n_o <= 1'b1;
      sdin_o <= ~sdin_o;
      rsp_v_o <= 1'b1;
      @(posedge ref_clk_i) rsp_v_o <= 1'b0;
      repeat (10) @(posedge ref_clk_i);
   endtask
endmodule
`default_nettype wire

// [verif/wotp_ctrl_test.sv]
// Self-checking bench of the wiper and store controller.
// Assumes the host model and the bound checker beside it.
`timescale 1ns/1ps
`default_nettype none
module wotp_ctrl_test;
   import wotp_pkg::*;
   localparam int SC = 400;
   logic               ref_clk_i;
   logic               rst_b_i;
   logic               hw_reset_n_i;
   logic               sclk_i;
   logic               sdin_i;
   logic               frame_select_n_i;
   logic               sdo_o;
   logic               program_done_o;
   logic               calibration_select_o;
   logic [WIPER_W-1:0] wiper_o;
   logic [15:0]        rsp;
   logic               rsp_v;
   logic [16:0]        exp_q[$];
   logic [9:0]         wv;
   logic [15:0]        prev;
   int                 failures;
   int                 num_checks;

   wotp_ctrl #(.STORE_CYC(SC)) dut (.ref_clk_i, .rst_b_i, .sclk_i, .sdin_i,
      .frame_select_n_i, .sdo_o, .hw_reset_n_i, .program_done_o, .wiper_o,
      .calibration_select_o);
   wotp_host u_host (.ref_clk_i, .sdo_i(sdo_o), .sclk_o(sclk_i), .sdin_o(sdin_i),
      .frame_select_n_o(frame_select_n_i), .rsp_o(rsp), .rsp_v_o(rsp_v));

   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end

   task automatic final_report();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // A flag of 0 marks a reply nobody can predict
   task automatic frame(input logic [15:0] w, input logic v, input logic [15:0] e);
      exp_q.push_back({v, e});
      u_host.xfer({16'h0000, w}, 16);
   endtask

   task automatic store_wait();
      int k;
      k = 0;
      while (program_done_o !== 1'b1 && k < SC + 200) begin
         @(posedge ref_clk_i);
         k++;
      end
      if (k == SC + 200) begin
         failures++;
         $display("[FAIL] %0t store never finished", $time);
         final_report();
      end
   endtask

   initial begin
      logic [16:0] n;
      forever begin
         @(posedge rsp_v);
         n = exp_q.pop_front();
         if (n[16]) check(rsp, n[15:0]);
      end
   end

   initial begin
      failures = 0;
      num_checks = 0;
      rst_b_i = 1'b0;
      hw_reset_n_i = 1'b1;
      void'($urandom(74));
      repeat (16) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      check({6'h00, wiper_o}, {6'h00, MIDSCALE});
      check({14'h0000, calibration_select_o, program_done_o}, 16'h0001);
      frame(16'h1C00, 1'b0, 16'h0000);
      frame(16'h0500, 1'b1, 16'h0000);
      check({6'h00, wiper_o}, 16'h0200);
      frame(16'h0800, 1'b1, 16'h0500);
      frame(16'h1802, 1'b1, 16'h0200);
      frame(16'h0C00, 1'b1, 16'h1802);
      check({15'h0000, program_done_o}, 16'h0001);
      $display("test 1 done");
      frame(16'h1803, 1'b1, 16'h0C00);
      prev = 16'h1803;
      for (int i = 0; i < 6; i++) begin
         wv = (i == 0) ? 10'h100 : (i == 1) ? 10'h000 : (i == 2) ? 10'h3FF : 10'($urandom());
         frame({2'b00, CMD_WR_WIPER, wv}, 1'b1, prev);
         prev = {2'b00, CMD_WR_WIPER, wv};
         check({6'h00, wiper_o}, {6'h00, wv});
      end
      $display("test 2 done");
      frame(16'h1BF7, 1'b1, prev);
      check({15'h0000, calibration_select_o}, 16'h0001);
      frame(16'h1C00, 1'b1, 16'h1BF7);
      frame(16'h0555, 1'b1, 16'h0007);
      $display("test 3 done");
      frame(16'h0C00, 1'b1, 16'h0555);
      check({15'h0000, program_done_o}, 16'h0000);
      frame(16'h0466, 1'b0, 16'h0000);
      check({6'h00, wiper_o}, 16'h0155);
      store_wait();
      frame(16'h1C00, 1'b0, 16'h0000);
      frame(16'h1400, 1'b1, 16'h000F);
      frame(16'h1414, 1'b1, 16'h0155);
      frame(16'h1415, 1'b1, 16'h0001);
      frame(16'h04AA, 1'b1, 16'h0000);
      $display("test 4 done");
      frame(16'h1000, 1'b1, 16'h04AA);
      check({5'h00, calibration_select_o, wiper_o}, 16'h0155);
      frame(16'h1803, 1'b1, 16'h1000);
      frame(16'h0433, 1'b1, 16'h1803);
      @(posedge ref_clk_i) hw_reset_n_i <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      hw_reset_n_i <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      check({6'h00, wiper_o}, 16'h0155);
      $display("test 5 done");
      frame(16'h1803, 1'b1, 16'h0433);
      exp_q.push_back(17'h00000);
      u_host.xfer(32'h0000_0499, 15);
      check({6'h00, wiper_o}, 16'h0155);
      exp_q.push_back(17'h00000);
      u_host.xfer(32'h0000_0466, 32);
      check({6'h00, wiper_o}, 16'h0066);
      $display("test 6 done");
      for (int i = 1; i < 20; i++) begin
         frame({2'b00, CMD_WR_WIPER, 10'(i)}, 1'b0, 16'h0000);
         frame(16'h0C00, 1'b0, 16'h0000);
         store_wait();
      end
      frame(16'h0C00, 1'b0, 16'h0000);
      check({15'h0000, program_done_o}, 16'h0001);
      frame(16'h1C00, 1'b0, 16'h0000);
      frame(16'h1413, 1'b1, 16'h0003);
      frame(16'h1415, 1'b1, 16'h0013);
      frame(16'h0000, 1'b1, 16'h03FF);
      $display("test 7 done");
      repeat (20) @(posedge ref_clk_i);
      final_report();
   end
endmodule

bind wotp_ctrl wotp_ctrl_props #(.STORE_CYC(STORE_CYC)) u_props (.ref_clk_i, .rst_b_i,
   .sclk_i, .sdin_i, .frame_select_n_i, .sdo_o, .hw_reset_n_i, .program_done_o,
   .wiper_o, .calibration_select_o);
`default_nettype wire
